// >>> clock_irq_pkg.sv
// package: register map, field positions and types for the clock ready interrupt unit
package clock_irq_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] EVENT_CONTROL_OFFSET = 8'h08;
  localparam logic [31:0] EVENT_CONTROL_RESET = 32'h00000000;
  localparam int unsigned NUM_SOURCES = 8;
  localparam int unsigned FLAG_LSB = 0;
  localparam int unsigned ENABLE_LSB = 8;
  localparam int unsigned CLEAR_LSB = 16;
  localparam int unsigned STUCK_BIT = 7;
  localparam logic [6:0] ENABLE_RESET = 7'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [31:0] READ_RESET = 32'h00000000;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  // readiness sources; bit index equals flag position
  typedef struct packed {
    logic crystal_stuck;
    logic synth_c;
    logic synth_b;
    logic synth_main;
    logic fast_crystal_osc;
    logic fast_rc_osc;
    logic slow_crystal_osc;
    logic slow_rc_osc;
  } src_type;
endpackage : clock_irq_pkg

// >>> clock_ready_interrupt_unit.sv
// clock ready interrupt unit: flags, enables, clears and interrupt request
// What this block does
// RQ1: control register resets to zero and sits at byte offset 0x08.
// RQ2: software writes zeros to bits 31:24 and bit 15.
// RQ3: stuck flag bit 7 sets on crystal stop, clears by one at bit 23.
// RQ4: bit 6 sets on third synth ready with enable 14; bit 22 clears.
// RQ5: bit 5 sets on second synth ready with enable 13; bit 21 clears.
// RQ6: bit 4 sets on main synth ready with enable 12; bit 20 clears.
// RQ7: bit 3 sets on fast crystal ready with enable 11; bit 19 clears.
// RQ8: bit 2 sets on fast RC ready with enable 10; bit 18 clears.
// RQ9: bit 1 sets on slow crystal ready with enable 9; bit 17 clears.
// RQ10: bit 0 sets on slow RC ready with enable 8; bit 16 clears.
// RQ11: enable bits 14:8 are plain read-write bits.
// RQ12: writing zero to a clear bit leaves its flag unchanged.
// RQ13: interrupt request high while any flag in bits 7:0 is one.
// RQ14: clear bits read as zero and hold no state.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module clock_ready_interrupt_unit (
  input wire logic clk,
  input wire logic srst,
  input wire clock_irq_pkg::bus_req_type bus_req,
  output logic [31:0] rdata,
  input wire clock_irq_pkg::src_type src_ready,
  output logic irq
);
  logic [6:0] enable_q;
  logic [7:0] flag_q;
  logic [31:0] rdata_q;
  logic [7:0] rise;
  logic [7:0] set_ev;
  logic [7:0] clr_ev;
  logic [7:0] gate;
  logic hit;

  ready_edge_detect u_edge (
    .clk(clk),
    .srst(srst),
    .level(src_ready),
    .rise(rise)
  );

  assign hit = (bus_req.addr == clock_irq_pkg::EVENT_CONTROL_OFFSET); // [RQ1]

  // stuck flag has no enable; the stabilization flags are gated by their enables
  assign gate = {1'b1, enable_q};

  // per-source set and clear; besides reset, a one at the clear bit is the only way to drop a flag
  genvar i;
  generate
    for (i = 0; i < clock_irq_pkg::NUM_SOURCES; i++) begin : g_src
      assign set_ev[i] = rise[i] & gate[i]; // [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8] [RQ9] [RQ10]
      assign clr_ev[i] = bus_req.wr & hit & bus_req.wdata[clock_irq_pkg::CLEAR_LSB + i]; // [RQ12]
    end
  endgenerate

  // flags: a set arriving with its clear wins so no event is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= clock_irq_pkg::FLAG_RESET; // [RQ1]
    end else begin
      flag_q <= (flag_q & ~clr_ev) | set_ev; // [RQ3] [RQ12]
    end
  end

  // enables are plain storage
  always_ff @(posedge clk) begin
    if (srst) begin
      enable_q <= clock_irq_pkg::ENABLE_RESET; // [RQ1]
    end else if (bus_req.wr && hit) begin
      enable_q <= bus_req.wdata[clock_irq_pkg::ENABLE_LSB +: 7]; // [RQ11]
    end
  end

  // read data valid one cycle after the strobe only; clear and reserved bits read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= clock_irq_pkg::READ_RESET;
    end else if (bus_req.rd && hit) begin
      rdata_q <= {16'h0000, 1'b0, enable_q, flag_q}; // [RQ14]
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign rdata = rdata_q;
  assign irq = |flag_q; // [RQ13]

  // flag rises one cycle after a gated rising edge
  flag_set_a: assert property (@(posedge clk) disable iff (srst)
    set_ev[3] |=> flag_q[3]) else $error("ready flag not set"); // [RQ7]

  stuck_set_a: assert property (@(posedge clk) disable iff (srst)
    rise[clock_irq_pkg::STUCK_BIT] |=> flag_q[clock_irq_pkg::STUCK_BIT])
    else $error("stuck flag not set"); // [RQ3]

  gated_off_a: assert property (@(posedge clk) disable iff (srst)
    (!flag_q[6] && !enable_q[6]) |=> !flag_q[6]) else $error("flag set while disabled"); // [RQ4]

  zero_keep_a: assert property (@(posedge clk) disable iff (srst)
    (flag_q[0] && !clr_ev[0]) |=> flag_q[0]) else $error("flag lost without clear"); // [RQ12]

  one_clear_a: assert property (@(posedge clk) disable iff (srst)
    (clr_ev[5] && !set_ev[5]) |=> !flag_q[5]) else $error("flag not cleared"); // [RQ5]

  irq_level_a: assert property (@(posedge clk) disable iff (srst)
    irq == (flag_q != 8'h00)) else $error("irq mismatch"); // [RQ13]

  enable_wr_a: assert property (@(posedge clk) disable iff (srst)
    (bus_req.wr && hit) |=> enable_q == $past(bus_req.wdata[14:8]))
    else $error("enable write lost"); // [RQ11]

  read_zero_a: assert property (@(posedge clk) disable iff (srst)
    (bus_req.rd && hit) |=> rdata[31:15] == 17'h00000) else $error("clear bits read nonzero"); // [RQ14]

  read_back_a: assert property (@(posedge clk) disable iff (srst)
    (bus_req.rd && hit) |=> rdata[14:0] == $past({enable_q, flag_q}))
    else $error("readback mismatch"); // [RQ1]

  reset_zero_a: assert property (@(posedge clk)
    srst |=> (flag_q == 8'h00 && enable_q == 7'h00)) else $error("reset value wrong"); // [RQ1]

  cover_irq_c: cover property (@(posedge clk) disable iff (srst) !irq ##1 irq);
  cover_clear_c: cover property (@(posedge clk) disable iff (srst) irq ##1 clr_ev[2] ##1 !irq);
  cover_race_c: cover property (@(posedge clk) disable iff (srst) set_ev[1] && clr_ev[1]);
  cover_stuck_c: cover property (@(posedge clk) disable iff (srst) rise[7] ##1 irq);
  cover_masked_c: cover property (@(posedge clk) disable iff (srst) rise[0] && !enable_q[0]);

  // set checks, one per gated source so that a failure names the source at once;
  // written against the raw edge and the enable, not against the internal set vector
  // third synthesizer
  synth_c_set_a: assert property (@(posedge clk) disable iff (srst) // [RQ4]
    (rise[6] && enable_q[6]) |=> flag_q[6])
    else $error("third synth flag not set");

  // second synthesizer
  synth_b_set_a: assert property (@(posedge clk) disable iff (srst) // [RQ5]
    (rise[5] && enable_q[5]) |=> flag_q[5])
    else $error("second synth flag not set");

  // main synthesizer
  synth_main_set_a: assert property (@(posedge clk) disable iff (srst) // [RQ6]
    (rise[4] && enable_q[4]) |=> flag_q[4])
    else $error("main synth flag not set");

  // fast crystal
  fast_crystal_set_a: assert property (@(posedge clk) disable iff (srst) // [RQ7]
    (rise[3] && enable_q[3]) |=> flag_q[3])
    else $error("fast crystal flag not set");

  // fast rc
  fast_rc_set_a: assert property (@(posedge clk) disable iff (srst) // [RQ8]
    (rise[2] && enable_q[2]) |=> flag_q[2])
    else $error("fast rc flag not set");

  // slow crystal
  slow_crystal_set_a: assert property (@(posedge clk) disable iff (srst) // [RQ9]
    (rise[1] && enable_q[1]) |=> flag_q[1])
    else $error("slow crystal flag not set");

  // slow rc
  slow_rc_set_a: assert property (@(posedge clk) disable iff (srst) // [RQ10]
    (rise[0] && enable_q[0]) |=> flag_q[0])
    else $error("slow rc flag not set");

  // clear checks: a one at the clear bit drops the flag unless a set lands with it
  // third synthesizer
  synth_c_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ4]
    (bus_req.wr && hit && bus_req.wdata[22] && !(rise[6] && enable_q[6])) |=> !flag_q[6])
    else $error("third synth flag not cleared");

  // second synthesizer
  synth_b_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ5]
    (bus_req.wr && hit && bus_req.wdata[21] && !(rise[5] && enable_q[5])) |=> !flag_q[5])
    else $error("second synth flag not cleared");

  // main synthesizer
  synth_main_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ6]
    (bus_req.wr && hit && bus_req.wdata[20] && !(rise[4] && enable_q[4])) |=> !flag_q[4])
    else $error("main synth flag not cleared");

  // fast crystal
  fast_crystal_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ7]
    (bus_req.wr && hit && bus_req.wdata[19] && !(rise[3] && enable_q[3])) |=> !flag_q[3])
    else $error("fast crystal flag not cleared");

  // fast rc
  fast_rc_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ8]
    (bus_req.wr && hit && bus_req.wdata[18] && !(rise[2] && enable_q[2])) |=> !flag_q[2])
    else $error("fast rc flag not cleared");

  // slow crystal
  slow_crystal_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ9]
    (bus_req.wr && hit && bus_req.wdata[17] && !(rise[1] && enable_q[1])) |=> !flag_q[1])
    else $error("slow crystal flag not cleared");

  // slow rc
  slow_rc_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ10]
    (bus_req.wr && hit && bus_req.wdata[16] && !(rise[0] && enable_q[0])) |=> !flag_q[0])
    else $error("slow rc flag not cleared");

  // crystal stuck: no enable, so only a new stuck edge can beat the clear
  stuck_clr_a: assert property (@(posedge clk) disable iff (srst) // [RQ3]
    (bus_req.wr && hit && bus_req.wdata[23] && !rise[7]) |=> !flag_q[7])
    else $error("stuck flag not cleared");

  // gating checks: a disabled source never raises its flag
  // third synthesizer
  synth_c_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ4]
    (!enable_q[6] && !flag_q[6]) |=> !flag_q[6])
    else $error("third synth flag set while disabled");

  // second synthesizer
  synth_b_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ5]
    (!enable_q[5] && !flag_q[5]) |=> !flag_q[5])
    else $error("second synth flag set while disabled");

  // main synthesizer
  synth_main_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ6]
    (!enable_q[4] && !flag_q[4]) |=> !flag_q[4])
    else $error("main synth flag set while disabled");

  // fast crystal
  fast_crystal_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ7]
    (!enable_q[3] && !flag_q[3]) |=> !flag_q[3])
    else $error("fast crystal flag set while disabled");

  // fast rc
  fast_rc_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ8]
    (!enable_q[2] && !flag_q[2]) |=> !flag_q[2])
    else $error("fast rc flag set while disabled");

  // slow crystal
  slow_crystal_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ9]
    (!enable_q[1] && !flag_q[1]) |=> !flag_q[1])
    else $error("slow crystal flag set while disabled");

  // slow rc
  slow_rc_off_a: assert property (@(posedge clk) disable iff (srst) // [RQ10]
    (!enable_q[0] && !flag_q[0]) |=> !flag_q[0])
    else $error("slow rc flag set while disabled");

  // keep checks: without a one at its clear bit a flag stays up
  // third synthesizer
  synth_c_keep_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    (flag_q[6] && !(bus_req.wr && hit && bus_req.wdata[22])) |=> flag_q[6])
    else $error("third synth flag lost");

  // second synthesizer
  synth_b_keep_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    (flag_q[5] && !(bus_req.wr && hit && bus_req.wdata[21])) |=> flag_q[5])
    else $error("second synth flag lost");

  // main synthesizer
  synth_main_keep_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    (flag_q[4] && !(bus_req.wr && hit && bus_req.wdata[20])) |=> flag_q[4])
    else $error("main synth flag lost");

  // fast crystal
  fast_crystal_keep_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    (flag_q[3] && !(bus_req.wr && hit && bus_req.wdata[19])) |=> flag_q[3])
    else $error("fast crystal flag lost");

  // fast rc
  fast_rc_keep_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    (flag_q[2] && !(bus_req.wr && hit && bus_req.wdata[18])) |=> flag_q[2])
    else $error("fast rc flag lost");

  // slow crystal
  slow_crystal_keep_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    (flag_q[1] && !(bus_req.wr && hit && bus_req.wdata[17])) |=> flag_q[1])
    else $error("slow crystal flag lost");

  // slow rc
  slow_rc_keep_a: assert property (@(posedge clk) disable iff (srst) // [RQ12]
    (flag_q[0] && !(bus_req.wr && hit && bus_req.wdata[16])) |=> flag_q[0])
    else $error("slow rc flag lost");

  // crystal stuck
  stuck_keep_a: assert property (@(posedge clk) disable iff (srst) // [RQ3]
    (flag_q[7] && !(bus_req.wr && hit && bus_req.wdata[23])) |=> flag_q[7])
    else $error("stuck flag lost");

  // read data stand for one cycle only; the bus sees zero otherwise
  rd_idle_a: assert property (@(posedge clk) disable iff (srst) // [RQ14]
    !(bus_req.rd && hit) |=> rdata == 32'h00000000)
    else $error("read data outside the read cycle");

  // enables read back as they stood when the strobe was taken
  enable_read_a: assert property (@(posedge clk) disable iff (srst) // [RQ11]
    (bus_req.rd && hit) |=> rdata[14:8] == $past(enable_q))
    else $error("enable readback mismatch");

  // a write to another offset leaves the enables alone
  other_wr_a: assert property (@(posedge clk) disable iff (srst) // [RQ1]
    (bus_req.wr && !hit) |=> enable_q == $past(enable_q))
    else $error("enable changed by foreign write");

  // enables only move on a decoded write
  enable_hold_a: assert property (@(posedge clk) disable iff (srst) // [RQ11]
    !(bus_req.wr && hit) |=> enable_q == $past(enable_q))
    else $error("enable changed without write");

  // a set and its clear in one cycle: the set wins so no event is lost
  set_wins_a: assert property (@(posedge clk) disable iff (srst) // [RQ9]
    (rise[1] && enable_q[1] && bus_req.wr && hit && bus_req.wdata[17]) |=> flag_q[1])
    else $error("set lost to clear");

  // any accepted event raises the request on the next cycle
  irq_rise_a: assert property (@(posedge clk) disable iff (srst) // [RQ13]
    (rise[7] || (rise[6:0] & enable_q) != 7'h00) |=> irq)
    else $error("irq not raised");

  // clearing every pending flag with no new event drops the request
  irq_fall_a: assert property (@(posedge clk) disable iff (srst) // [RQ13]
    (bus_req.wr && hit && (flag_q & ~bus_req.wdata[23:16]) == 8'h00 && rise == 8'h00) |=> !irq)
    else $error("irq not dropped");

  // the stuck flag ignores the enables
  stuck_ungated_a: assert property (@(posedge clk) disable iff (srst) // [RQ3]
    (rise[7] && enable_q == 7'h00) |=> flag_q[7])
    else $error("stuck flag gated");

  // reading has no side effect on the flags
  rd_no_side_a: assert property (@(posedge clk) disable iff (srst) // [RQ14]
    (bus_req.rd && rise == 8'h00) |=> flag_q == $past(flag_q))
    else $error("read disturbed flags");

  // a write to another offset clears nothing
  wr_other_flags_a: assert property (@(posedge clk) disable iff (srst) // [RQ1]
    (bus_req.wr && !hit && rise == 8'h00) |=> flag_q == $past(flag_q))
    else $error("foreign write cleared a flag");

  // per flag: a held level sets nothing, and a pending flag always shows on irq
  for (genvar k = 0; k < clock_irq_pkg::NUM_SOURCES; k++) begin : g_chk
    edge_only_a: assert property (@(posedge clk) disable iff (srst) // [RQ3]
      (!flag_q[k] && !rise[k]) |=> !flag_q[k])
      else $error("flag set without a source edge");
    flag_irq_a: assert property (@(posedge clk) disable iff (srst) // [RQ13]
      flag_q[k] |-> irq)
      else $error("flag pending without irq");
  end
endmodule : clock_ready_interrupt_unit

// >>> osc_model.sv
// clock source model: readiness levels toward the unit
`timescale 1ns/1ps
module osc_model (
  input wire logic clk,
  input wire logic [7:0] want,
  output clock_irq_pkg::src_type ready
);
  // levels settle just after an edge, as a real source would
  initial ready = '0;
  always @(posedge clk) ready <= clock_irq_pkg::src_type'(want);
endmodule : osc_model

// >>> ready_edge_detect.sv
// rising edge detector for the source readiness levels
`timescale 1ns/1ps
module ready_edge_detect (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] level,
  output logic [7:0] rise
);
  logic [7:0] prev_q;

  // previous level; reset to zero so a source already ready reports once
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= 8'h00;
    end else begin
      prev_q <= level;
    end
  end

  assign rise = level & ~prev_q;
endmodule : ready_edge_detect

// >>> tb.sv
// self-checking bench for the clock ready interrupt unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  clock_irq_pkg::bus_req_type req = '0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [7:0] want = 8'h00;
  clock_irq_pkg::src_type ready;
  logic irq;
  int n_errors = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  osc_model osc (.clk(clk), .want(want), .ready(ready));
  clock_ready_interrupt_unit dut (.clk(clk), .srst(srst), .bus_req(req), .rdata(rdata),
    .src_ready(ready), .irq(irq));
  // one-cycle write strobe; reserved bits always go out as zero
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk) req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic sc_reset();
    rd(8'h08, v);
    `CHK("reset", 32'h0, v)
    `CHK("irq", 1'b0, irq)
    @(posedge clk);
    #1;
    `CHK("rd idle", 32'h0, rdata)
  endtask : sc_reset
  task automatic sc_sources();
    for (int i = 0; i < 7; i++) begin
      wr(8'h08, 32'h1 << (8 + i));
      want <= 8'h1 << i;
      repeat (3) @(posedge clk);
      rd(8'h08, v);
      `CHK("set", 32'h101 << i, v)
      `CHK("irq", 1'b1, irq)
      wr(8'h08, 32'h0);
      rd(8'h08, v);
      `CHK("keep", 32'h1 << i, v)
      wr(8'h08, 32'h1 << (16 + i));
      want <= 8'h0;
      rd(8'h08, v);
      `CHK("clear", 32'h0, v)
      `CHK("irq", 1'b0, irq)
    end
  endtask : sc_sources
  // sources rising while disabled must leave no trace
  task automatic sc_masked();
    want <= 8'h7f;
    repeat (3) @(posedge clk);
    want <= 8'h00;
    rd(8'h08, v);
    `CHK("masked", 32'h0, v)
  endtask : sc_masked
  task automatic sc_stuck();
    want <= 8'h80;
    repeat (3) @(posedge clk);
    want <= 8'h00;
    wr(8'h08, 32'h007f_0000);
    rd(8'h08, v);
    `CHK("stuck", 32'h80, v)
    `CHK("irq", 1'b1, irq)
    rd(8'h0c, v);
    `CHK("unmapped", 32'h0, v)
    wr(8'h08, 32'h0080_0000);
    rd(8'h08, v);
    `CHK("unstuck", 32'h0, v)
    `CHK("irq", 1'b0, irq)
  endtask : sc_stuck
  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    sc_reset();
    sc_sources();
    sc_masked();
    sc_stuck();
    print_verdict();
  end
endmodule : tb
